// >>> arr_consts.svh
// Constants for the converter result register bank, slots three to five.
`ifndef ARR_CONSTS_SVH
`define ARR_CONSTS_SVH

// Bus geometry.
`define ARR_ADDR_W 8
`define ARR_DATA_W 32
`define ARR_STRB_W 4
`define ARR_NUM_SLOTS 3
`define ARR_SLOT_IDX_W 2

// Register byte offsets.
`define ARR_OFS_SLOT_THREE 8'h00
`define ARR_OFS_SLOT_FOUR 8'h04
`define ARR_OFS_SLOT_FIVE 8'h08
`define ARR_OFS_IRQ_STATUS 8'h10
`define ARR_OFS_IRQ_MASK 8'h14

// Result register field layout.
`define ARR_VAL_W 12
`define ARR_VAL_LSB 4
`define ARR_VAL_MSB 15
`define ARR_OVR_BIT 1
`define ARR_RF_BIT 0

// Interrupt status layout: stored events low, overrun events above them.
`define ARR_IRQ_W 6
`define ARR_IRQ_STORE_LSB 0
`define ARR_IRQ_OVR_LSB 3

// Reset values.
`define ARR_RST_WORD 32'h0000_0000
`define ARR_RST_VAL 12'h000
`define ARR_RST_IRQ 6'h00

// Bus responses.
`define ARR_RESP_OKAY 2'h0
`define ARR_RESP_SLVERR 2'h2

`endif

// >>> arr_pkg.sv
// Types shared by the converter result register bank.
`include "arr_consts.svh"

package arr_pkg;

  // One result delivered by the converter sequencing logic.
  typedef struct packed {
    logic valid;
    logic [`ARR_SLOT_IDX_W-1:0] slot;
    logic [`ARR_VAL_W-1:0] value;
  } arr_conv_t;

  // Held contents of one result register.
  typedef struct packed {
    logic [`ARR_VAL_W-1:0] value;
    logic overrun;
    logic stored;
  } arr_slot_t;

  // Read channel sequencing.
  typedef enum logic {
    RD_IDLE,
    RD_RESP
  } arr_rd_state_t;

  // Write channel sequencing.
  typedef enum logic {
    WR_COLLECT,
    WR_RESP
  } arr_wr_state_t;

endpackage : arr_pkg

// >>> arr_slot.sv
// One conversion result register with its stored and overrun indicators.
`timescale 1ns/1ps
`default_nettype none
`include "arr_consts.svh"

module arr_slot
  import arr_pkg::*;
(
  input wire logic clk_i, // Peripheral clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic store_i, // New result arrives this cycle.
  input wire logic [`ARR_VAL_W-1:0] value_i, // Result value to store.
  input wire logic rd_clr_i, // Software read of the low byte.
  output arr_slot_t slot_o, // Held value and indicators.
  output logic ev_store_o, // Pulse: a result was stored.
  output logic ev_ovr_o // Pulse: a result overran an unread one.
);

  arr_slot_t slot_q;

  //////////////////////////////////////////////////////////////////////////
  // An overrun is a store while the previous result is still unread.
  // A read in the same cycle counts as reading the previous result.
  assign ev_store_o = store_i;
  assign ev_ovr_o = store_i && slot_q.stored && !rd_clr_i;
  assign slot_o = slot_q;

  //////////////////////////////////////////////////////////////////////////
  // Result value field, loaded on every store.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slot_q.value <= `ARR_RST_VAL;
    end
    else if (store_i)
    begin
      slot_q.value <= value_i;
    end
  end

  // Stored indicator: a store wins over a clearing read in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slot_q.stored <= 1'b0;
    end
    else if (store_i)
    begin
      slot_q.stored <= 1'b1;
    end
    else if (rd_clr_i)
    begin
      slot_q.stored <= 1'b0;
    end
  end

  // Overrun indicator: set on an overrun, cleared by the low byte read.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      slot_q.overrun <= 1'b0;
    end
    else if (ev_ovr_o)
    begin
      slot_q.overrun <= 1'b1;
    end
    else if (rd_clr_i)
    begin
      slot_q.overrun <= 1'b0;
    end
  end

endmodule : arr_slot
`default_nettype wire

// >>> arr_result_regs.sv
// Converter result registers for slots three to five behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
`include "arr_consts.svh"

module arr_result_regs
  import arr_pkg::*;
(
  input wire logic REF_CLK_I, // Peripheral clock, 20 MHz.
  input wire logic RESET_I, // Asynchronous reset, active high.
  // Converter side.
  input wire arr_conv_t CONV_I, // Result strobe, slot index and value.
  // AXI4-Lite write address channel.
  input wire logic S_AXI_AWVALID_I, // Write address valid.
  output logic S_AXI_AWREADY_O, // Write address ready.
  input wire logic [`ARR_ADDR_W-1:0] S_AXI_AWADDR_I, // Write byte address.
  input wire logic [2:0] S_AXI_AWPROT_I, // Protection, ignored.
  // AXI4-Lite write data channel.
  input wire logic S_AXI_WVALID_I, // Write data valid.
  output logic S_AXI_WREADY_O, // Write data ready.
  input wire logic [`ARR_DATA_W-1:0] S_AXI_WDATA_I, // Write data.
  input wire logic [`ARR_STRB_W-1:0] S_AXI_WSTRB_I, // Write byte strobes.
  // AXI4-Lite write response channel.
  output logic S_AXI_BVALID_O, // Write response valid.
  input wire logic S_AXI_BREADY_I, // Write response ready.
  output logic [1:0] S_AXI_BRESP_O, // Write response code.
  // AXI4-Lite read address channel.
  input wire logic S_AXI_ARVALID_I, // Read address valid.
  output logic S_AXI_ARREADY_O, // Read address ready.
  input wire logic [`ARR_ADDR_W-1:0] S_AXI_ARADDR_I, // Read byte address.
  input wire logic [2:0] S_AXI_ARPROT_I, // Protection, ignored.
  // AXI4-Lite read data channel.
  output logic S_AXI_RVALID_O, // Read data valid.
  input wire logic S_AXI_RREADY_I, // Read data ready.
  output logic [`ARR_DATA_W-1:0] S_AXI_RDATA_O, // Read data.
  output logic [1:0] S_AXI_RRESP_O, // Read response code.
  // Interrupt.
  output logic IRQ_O // Level, high while an unmasked event is pending.
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.
  arr_slot_t slot_s [`ARR_NUM_SLOTS];
  logic [`ARR_NUM_SLOTS-1:0] store_s;
  logic [`ARR_NUM_SLOTS-1:0] rd_clr_s;
  logic [`ARR_NUM_SLOTS-1:0] ev_store_s;
  logic [`ARR_NUM_SLOTS-1:0] ev_ovr_s;
  logic [`ARR_IRQ_W-1:0] irq_events_s;
  logic [`ARR_IRQ_W-1:0] irq_status_q;
  logic [`ARR_IRQ_W-1:0] irq_status_d;
  logic [`ARR_IRQ_W-1:0] irq_mask_q;
  logic [`ARR_IRQ_W-1:0] irq_w1c_s;
  arr_rd_state_t rd_state_q;
  arr_wr_state_t wr_state_q;
  logic [`ARR_DATA_W-1:0] rdata_q;
  logic [`ARR_DATA_W-1:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rd_take_s;
  logic [`ARR_ADDR_W-1:0] rd_word_addr_s;
  logic aw_got_q;
  logic w_got_q;
  logic [`ARR_ADDR_W-1:0] awaddr_q;
  logic [`ARR_DATA_W-1:0] wdata_q;
  logic [`ARR_STRB_W-1:0] wstrb_q;
  logic aw_take_s;
  logic w_take_s;
  logic aw_have_s;
  logic w_have_s;
  logic wr_fire_s;
  logic [`ARR_ADDR_W-1:0] wr_word_addr_s;
  logic [`ARR_DATA_W-1:0] wr_data_s;
  logic [`ARR_STRB_W-1:0] wr_strb_s;
  logic wr_status_s;
  logic wr_mask_s;

  //////////////////////////////////////////////////////////////////////////
  // Formats one result register word; unused bits stay zero.
  function automatic logic [`ARR_DATA_W-1:0] slot_word(input arr_slot_t s);
    logic [`ARR_DATA_W-1:0] w;
    w = `ARR_RST_WORD;
    w[`ARR_VAL_MSB:`ARR_VAL_LSB] = s.value;
    w[`ARR_OVR_BIT] = s.overrun;
    w[`ARR_RF_BIT] = s.stored;
    return w;
  endfunction : slot_word

  //////////////////////////////////////////////////////////////////////////
  // One result register per slot; each is stored and cleared on its own.
  for (genvar g = 0; g < `ARR_NUM_SLOTS; g++)
  begin : g_slot
    assign store_s[g] = CONV_I.valid &&
                        (CONV_I.slot == `ARR_SLOT_IDX_W'(g));
    arr_slot u_slot (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .store_i(store_s[g]),
      .value_i(CONV_I.value),
      .rd_clr_i(rd_clr_s[g]),
      .slot_o(slot_s[g]),
      .ev_store_o(ev_store_s[g]),
      .ev_ovr_o(ev_ovr_s[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Read channel: one outstanding read, address taken when idle.
  assign S_AXI_ARREADY_O = (rd_state_q == RD_IDLE);
  assign S_AXI_RVALID_O = (rd_state_q == RD_RESP);
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign rd_take_s = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign rd_word_addr_s = {S_AXI_ARADDR_I[`ARR_ADDR_W-1:2], 2'b00};

  // A bus read always spans the low byte, so every accepted read of a
  // result register clears that register's indicators only.
  always_comb
  begin
    rd_clr_s = '0;
    if (rd_take_s)
    begin
      rd_clr_s[0] = (rd_word_addr_s == `ARR_OFS_SLOT_THREE);
      rd_clr_s[1] = (rd_word_addr_s == `ARR_OFS_SLOT_FOUR);
      rd_clr_s[2] = (rd_word_addr_s == `ARR_OFS_SLOT_FIVE);
    end
  end

  // Read data decode; unmapped addresses read zero with an error.
  always_comb
  begin
    rdata_d = `ARR_RST_WORD;
    rresp_d = `ARR_RESP_OKAY;
    case (rd_word_addr_s)
      `ARR_OFS_SLOT_THREE: rdata_d = slot_word(slot_s[0]);
      `ARR_OFS_SLOT_FOUR: rdata_d = slot_word(slot_s[1]);
      `ARR_OFS_SLOT_FIVE: rdata_d = slot_word(slot_s[2]);
      `ARR_OFS_IRQ_STATUS: rdata_d[`ARR_IRQ_W-1:0] = irq_status_q;
      `ARR_OFS_IRQ_MASK: rdata_d[`ARR_IRQ_W-1:0] = irq_mask_q;
      default: rresp_d = `ARR_RESP_SLVERR;
    endcase
  end

  // Read sequencing.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      rd_state_q <= RD_IDLE;
    end
    else
    begin
      case (rd_state_q)
        RD_IDLE: if (rd_take_s) rd_state_q <= RD_RESP;
        RD_RESP: if (S_AXI_RREADY_I) rd_state_q <= RD_IDLE;
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  // Read data captured at the address handshake, before the flags clear.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      rdata_q <= `ARR_RST_WORD;
      rresp_q <= `ARR_RESP_OKAY;
    end
    else if (rd_take_s)
    begin
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.
  assign S_AXI_AWREADY_O = (wr_state_q == WR_COLLECT) && !aw_got_q;
  assign S_AXI_WREADY_O = (wr_state_q == WR_COLLECT) && !w_got_q;
  assign S_AXI_BVALID_O = (wr_state_q == WR_RESP);
  assign S_AXI_BRESP_O = bresp_q;
  assign aw_take_s = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_take_s = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign aw_have_s = aw_got_q || aw_take_s;
  assign w_have_s = w_got_q || w_take_s;
  assign wr_fire_s = (wr_state_q == WR_COLLECT) && aw_have_s && w_have_s;
  assign wr_word_addr_s = aw_got_q ? {awaddr_q[`ARR_ADDR_W-1:2], 2'b00}
                                   : {S_AXI_AWADDR_I[`ARR_ADDR_W-1:2], 2'b00};
  assign wr_data_s = w_got_q ? wdata_q : S_AXI_WDATA_I;
  assign wr_strb_s = w_got_q ? wstrb_q : S_AXI_WSTRB_I;
  assign wr_status_s = wr_fire_s && (wr_word_addr_s == `ARR_OFS_IRQ_STATUS) && wr_strb_s[0];
  assign wr_mask_s = wr_fire_s && (wr_word_addr_s == `ARR_OFS_IRQ_MASK) && wr_strb_s[0];

  // Write response: result registers accept and ignore writes.
  always_comb
  begin
    case (wr_word_addr_s)
      `ARR_OFS_SLOT_THREE,
      `ARR_OFS_SLOT_FOUR,
      `ARR_OFS_SLOT_FIVE,
      `ARR_OFS_IRQ_STATUS,
      `ARR_OFS_IRQ_MASK: bresp_d = `ARR_RESP_OKAY;
      default: bresp_d = `ARR_RESP_SLVERR;
    endcase
  end

  // Holding of a write address or data that arrived alone.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= `ARR_RST_WORD;
      wstrb_q <= '0;
    end
    else if (wr_fire_s)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end
    else
    begin
      if (aw_take_s)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (w_take_s)
      begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
    end
  end

  // Write sequencing and response code.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      wr_state_q <= WR_COLLECT;
      bresp_q <= `ARR_RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        WR_COLLECT:
        begin
          if (wr_fire_s)
          begin
            wr_state_q <= WR_RESP;
            bresp_q <= bresp_d;
          end
        end
        WR_RESP: if (S_AXI_BREADY_I) wr_state_q <= WR_COLLECT;
        default: wr_state_q <= WR_COLLECT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky events, write one to clear, set wins over clear.
  assign irq_events_s = {ev_ovr_s, ev_store_s};
  assign irq_w1c_s = wr_status_s ? wr_data_s[`ARR_IRQ_W-1:0] : '0;
  assign irq_status_d = (irq_status_q & ~irq_w1c_s) | irq_events_s;
  assign IRQ_O = |(irq_status_q & irq_mask_q);

  // Interrupt status register.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      irq_status_q <= `ARR_RST_IRQ;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  // Interrupt mask register.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      irq_mask_q <= `ARR_RST_IRQ;
    end
    else if (wr_mask_s)
    begin
      irq_mask_q <= wr_data_s[`ARR_IRQ_W-1:0];
    end
  end

endmodule : arr_result_regs
`default_nettype wire

// >>> arr_result_regs_monitor.sv
// Port checker for the converter result register bank.
`timescale 1ns/1ps
`default_nettype none
`include "arr_consts.svh"

module arr_result_regs_monitor
  import arr_pkg::*;
(
  input wire logic REF_CLK_I, // Clock.
  input wire logic RESET_I, // Reset.
  input wire arr_conv_t CONV_I, // Results.
  input wire logic S_AXI_AWVALID_I, // Write address valid.
  input wire logic S_AXI_AWREADY_O, // Write address ready.
  input wire logic S_AXI_WVALID_I, // Write data valid.
  input wire logic S_AXI_WREADY_O, // Write data ready.
  input wire logic S_AXI_BVALID_O, // Write response valid.
  input wire logic S_AXI_ARVALID_I, // Read address valid.
  input wire logic S_AXI_ARREADY_O, // Read address ready.
  input wire logic S_AXI_RVALID_O, // Read data valid.
  input wire logic S_AXI_RREADY_I, // Read data ready.
  input wire logic [`ARR_ADDR_W-1:0] S_AXI_ARADDR_I, // Read address.
  input wire logic [`ARR_DATA_W-1:0] S_AXI_RDATA_O, // Read data.
  input wire logic [1:0] S_AXI_RRESP_O // Read response.
);
  logic [2:0] st_q;
  logic [2:0] ov_q;
  logic [11:0] val_q [3];
  logic [13:0] exp_q;
  logic seen_q;
  wire logic ar_t = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire logic [1:0] ri = S_AXI_ARADDR_I[3:2];
  wire logic rs = ar_t && S_AXI_ARADDR_I[7:4] == 4'h0 && ri != 2'h3;
  wire logic mapped = S_AXI_ARADDR_I[7:2] inside {6'h00, 6'h01, 6'h02, 6'h04, 6'h05};

  // Reference copy of each slot, rebuilt from results and accepted reads.
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
    if (RESET_I)
    begin
      st_q <= 3'h0;
      ov_q <= 3'h0;
      val_q <= '{default: 12'h000};
      exp_q <= 14'h0000;
      seen_q <= 1'b0;
    end
    else
    begin
      if (CONV_I.valid && CONV_I.slot != 2'h3)
        seen_q <= 1'b1;
      if (rs)
        exp_q <= {val_q[ri], ov_q[ri], st_q[ri]};
      for (int i = 0; i < 3; i++)
      begin
        if (CONV_I.valid && CONV_I.slot == 2'(i))
          val_q[i] <= CONV_I.value;
        st_q[i] <= (CONV_I.valid && CONV_I.slot == 2'(i)) || (st_q[i] && !(rs && ri == 2'(i)));
        ov_q[i] <= !(rs && ri == 2'(i))
          && (ov_q[i] || (CONV_I.valid && CONV_I.slot == 2'(i) && st_q[i]));
      end
    end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  value_field_a: assert property (rs |=> S_AXI_RDATA_O[15:4] == exp_q[13:2])
    else $error("result value field wrong");
  flag_bits_a: assert property (rs |=> S_AXI_RDATA_O[1:0] == exp_q[1:0])
    else $error("stored or overrun flag wrong");
  reserved_zero_a: assert property (rs |=> S_AXI_RDATA_O[31:16] == 16'h0000 && S_AXI_RDATA_O[3:2] == 2'h0)
    else $error("reserved bits not zero");
  reset_word_a: assert property (rs && !seen_q |=> S_AXI_RDATA_O == `ARR_RST_WORD)
    else $error("result word not clear after reset");
  read_answer_a: assert property (ar_t |=> S_AXI_RVALID_O)
    else $error("read answer missing");
  read_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
    else $error("read answer not held");
  write_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
    else $error("write answer missing");
  write_block_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while answer pending");
  unmapped_read_a: assert property (ar_t && !mapped
    |=> S_AXI_RRESP_O == `ARR_RESP_SLVERR && S_AXI_RDATA_O == 32'h0000_0000)
    else $error("unmapped read answer wrong");
endmodule : arr_result_regs_monitor

bind arr_result_regs arr_result_regs_monitor u_mon (
  .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .CONV_I(CONV_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O)
);
`default_nettype wire

// >>> arr_conv_model.sv
// Behavioural model of the converter sequencing logic that delivers results.
`timescale 1ns/1ps
`default_nettype none
`include "arr_consts.svh"

module arr_conv_model
  import arr_pkg::*;
(
  input wire logic clk_i, // Peripheral clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic req_i, // Deliver one result next cycle.
  input wire logic [`ARR_SLOT_IDX_W-1:0] slot_i, // Target slot index.
  input wire logic [`ARR_VAL_W-1:0] value_i, // Result value.
  output arr_conv_t conv_o // One-cycle result strobe to the bank.
);
  // Between strobes the payload keeps toggling, so a bank that samples it
  // without the strobe stores garbage and is caught.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      conv_o <= '0;
    else
    begin
      conv_o.valid <= req_i;
      conv_o.slot <= req_i ? slot_i : ~conv_o.slot;
      conv_o.value <= req_i ? value_i : ~conv_o.value;
    end
endmodule : arr_conv_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the converter result register bank.
`timescale 1ns/1ps
`default_nettype none
`include "arr_consts.svh"

module tb_top
  import arr_pkg::*;
;
  logic clk, rst, req, awv, wv, br, arv, rr, awrdy, wrdy, bv, arrdy, rv, irq;
  logic [1:0] cs, bp, rp;
  logic [3:0] ws;
  logic [7:0] awa, ara;
  logic [11:0] cv;
  logic [31:0] wd, rd;
  arr_conv_t conv;
  int err_total, tests_run;
  logic [7:0] ofs [3] = '{`ARR_OFS_SLOT_THREE, `ARR_OFS_SLOT_FOUR, `ARR_OFS_SLOT_FIVE};
  logic [11:0] vals [3] = '{12'hFFF, 12'hABC, 12'h001};

  arr_conv_model u_conv (.clk_i(clk), .rst_i(rst), .req_i(req), .slot_i(cs), .value_i(cv),
    .conv_o(conv));
  arr_result_regs u_dut (.REF_CLK_I(clk), .RESET_I(rst), .CONV_I(conv),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rp), .IRQ_O(irq));

  // Free-running 20 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Handshakes are judged at the falling edge, where ready and data are settled.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic at, wt, bt;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    br <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk);
      at = awv && awrdy;
      wt = wv && wrdy;
      bt = bv && br;
      r = bp;
      @(posedge clk);
      if (at)
        awv <= 1'b0;
      if (wt)
        wv <= 1'b0;
      if (bt)
      begin
        br <= 1'b0;
        return;
      end
    end
    err_total++;
    give_verdict();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at, rt;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge clk);
      at = arv && arrdy;
      rt = rv && rr;
      d = rd;
      r = rp;
      @(posedge clk);
      if (at)
        arv <= 1'b0;
      if (rt)
      begin
        rr <= 1'b0;
        return;
      end
    end
    err_total++;
    give_verdict();
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask : rd_chk

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, s, r);
    check({30'h0, r}, {30'h0, er});
  endtask : wr_chk

  task automatic irq_chk(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_chk

  // Sends n back-to-back results to one slot, the value counting up.
  task automatic put(input logic [1:0] s, input logic [11:0] v, input int n);
    @(posedge clk);
    req <= 1'b1;
    cs <= s;
    cv <= v;
    repeat (n - 1) @(posedge clk) cv <= cv + 12'h001;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : put

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 3; i++)
      rd_chk(ofs[i], `ARR_RST_WORD, `ARR_RESP_OKAY);
    rd_chk(`ARR_OFS_IRQ_STATUS, 32'h0, `ARR_RESP_OKAY);
    rd_chk(`ARR_OFS_IRQ_MASK, 32'h0, `ARR_RESP_OKAY);
    irq_chk(1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_store();
    for (int i = 0; i < 3; i++)
    begin
      put(2'(i), vals[i], 1);
      rd_chk(ofs[i], {16'h0, vals[i], 4'h1}, `ARR_RESP_OKAY);
      rd_chk(ofs[i], {16'h0, vals[i], 4'h0}, `ARR_RESP_OKAY);
    end
    put(2'h3, 12'h555, 1);
    for (int i = 0; i < 3; i++)
      rd_chk(ofs[i], {16'h0, vals[i], 4'h0}, `ARR_RESP_OKAY);
    $display("test store done");
  endtask : t_store

  task automatic t_bus();
    wr_chk(ofs[0], 32'hFFFF_FFFF, 4'hF, `ARR_RESP_OKAY);
    rd_chk(ofs[0], {16'h0, vals[0], 4'h0}, `ARR_RESP_OKAY);
    wr_chk(8'h20, 32'h0000_0001, 4'hF, `ARR_RESP_SLVERR);
    rd_chk(8'h20, 32'h0, `ARR_RESP_SLVERR);
    $display("test bus done");
  endtask : t_bus

  task automatic t_overrun();
    int j;
    for (int i = 0; i < 3; i++)
    begin
      j = (i + 1) % 3;
      put(2'(i), 12'h7F0, 2);
      put(2'(j), 12'h00F, 1);
      rd_chk(ofs[i], {16'h0, 12'h7F1, 4'h3}, `ARR_RESP_OKAY);
      rd_chk(ofs[j], {16'h0, 12'h00F, 4'h1}, `ARR_RESP_OKAY);
      rd_chk(ofs[j], {16'h0, 12'h00F, 4'h0}, `ARR_RESP_OKAY);
    end
    $display("test overrun done");
  endtask : t_overrun

  // Masked event, unmasked event, strobe-less clear ignored, then a real clear.
  task automatic t_irq();
    wr_chk(`ARR_OFS_IRQ_STATUS, 32'h3F, 4'hF, `ARR_RESP_OKAY);
    irq_chk(1'b0);
    put(2'h1, 12'h123, 2);
    rd_chk(`ARR_OFS_IRQ_STATUS, 32'h12, `ARR_RESP_OKAY);
    irq_chk(1'b0);
    wr_chk(`ARR_OFS_IRQ_MASK, 32'h10, 4'hF, `ARR_RESP_OKAY);
    irq_chk(1'b1);
    rd_chk(`ARR_OFS_IRQ_MASK, 32'h10, `ARR_RESP_OKAY);
    wr_chk(`ARR_OFS_IRQ_STATUS, 32'h10, 4'h0, `ARR_RESP_OKAY);
    irq_chk(1'b1);
    wr_chk(`ARR_OFS_IRQ_STATUS, 32'h10, 4'h1, `ARR_RESP_OKAY);
    irq_chk(1'b0);
    rd_chk(`ARR_OFS_IRQ_STATUS, 32'h02, `ARR_RESP_OKAY);
    $display("test interrupt done");
  endtask : t_irq

  // A reset in mid-run must clear a value, both flags, status and mask left by traffic.
  task automatic t_rerun();
    put(2'h2, 12'hABC, 2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rerun

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    {req, awv, wv, br, arv, rr} = 6'h00;
    {cs, ws, awa, ara, cv, wd} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_store();
    t_bus();
    t_overrun();
    t_irq();
    t_rerun();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
